//--- common/bpio_pkg.sv
// Package for the bidirectional parallel I/O ports: map, masks, carriers
package bpio_pkg;
  localparam int BPIO_NUM_PORTS = 4;
  localparam int BPIO_PORT_W = 8;
  localparam int BPIO_ADDR_W = 12;
  // Printed offsets are register indexes; byte address is index times four
  localparam logic [3:0] BPIO_IDX_A_DATA = 4'h0;
  localparam logic [3:0] BPIO_IDX_B_DATA = 4'h1;
  localparam logic [3:0] BPIO_IDX_C_DATA = 4'h2;
  localparam logic [3:0] BPIO_IDX_D_DATA = 4'h3;
  localparam logic [3:0] BPIO_IDX_A_DIR = 4'h4;
  localparam logic [3:0] BPIO_IDX_B_DIR = 4'h5;
  localparam logic [3:0] BPIO_IDX_C_DIR = 4'h6;
  localparam logic [3:0] BPIO_IDX_D_DIR = 4'h7;
  localparam int BPIO_IDX_LSB = 2;
  localparam logic [3:0] BPIO_IDX_LAST = 4'h7;
  // Implemented bits per port: data latch, direction, input-only
  localparam logic [31:0] BPIO_DATA_MASK = 32'ha0ffe0ff;
  localparam logic [31:0] BPIO_DIR_MASK = 32'h20ffe0ff;
  localparam logic [31:0] BPIO_IN_ONLY_MASK = 32'h80000000;
  localparam logic [7:0] BPIO_DIR_RESET = 8'h00;
  localparam logic [31:0] BPIO_RDATA_IDLE = 32'h00000000;

  // Pin drive word: output value and enable, one bit per pin
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } bpio_pin_drive_t;
endpackage

//--- verilog/bpio_ports.sv
// Four-port bidirectional parallel I/O block behind an APB slave
`timescale 1ns/10ps
`default_nettype none
module bpio_ports
  import bpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [BPIO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe
);

  logic [31:0] data_q;
  logic [31:0] dir_q;
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  bpio_pin_drive_t drive_q;
  logic [3:0] idx;
  logic addr_ok;
  logic setup;
  logic wr_en;
  logic [31:0] pin_view;

  // Map must fill one word and leave room for the index field
  if (BPIO_NUM_PORTS * BPIO_PORT_W != 32 ||
      BPIO_ADDR_W < BPIO_IDX_LSB + 5) begin : g_bad_map
    $error("port map does not fit the decode logic");
  end

  // Decode of the word index; unmapped words answer with an error
  assign idx = paddr[BPIO_IDX_LSB +: 4];
  assign addr_ok = (paddr[1:0] == 2'b00) &&
                   (paddr[BPIO_ADDR_W-1:BPIO_IDX_LSB+4] == '0) &&
                   (idx <= BPIO_IDX_LAST);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && addr_ok && pready_q;

  // Two-flop synchroniser for pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Data latches, no reset: contents survive reset
  always_ff @(posedge pclk) begin
    if (wr_en && idx <= BPIO_IDX_D_DATA && pstrb[0]) begin
      data_q[idx[1:0]*8 +: 8] <= pwdata[7:0] &
        BPIO_DATA_MASK[idx[1:0]*8 +: 8];
    end
  end

  // Direction registers, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= {4{BPIO_DIR_RESET}};
    end else if (wr_en && idx >= BPIO_IDX_A_DIR && pstrb[0]) begin
      dir_q[idx[1:0]*8 +: 8] <= pwdata[7:0] &
        BPIO_DIR_MASK[idx[1:0]*8 +: 8];
    end
  end

  // Per bit: output reads latch, input reads pin
  assign pin_view = ((dir_q & data_q) | (~dir_q & sync2_q)) &
                    BPIO_DATA_MASK;

  // APB answer in the access phase; data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= BPIO_RDATA_IDLE;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !addr_ok;
        prdata_q <= BPIO_RDATA_IDLE;
        if (addr_ok && !pwrite) begin
          if (idx <= BPIO_IDX_D_DATA) begin
            prdata_q[7:0] <= pin_view[idx[1:0]*8 +: 8];
          end else begin
            prdata_q[7:0] <= dir_q[idx[1:0]*8 +: 8];
          end
        end
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= BPIO_RDATA_IDLE;
      end
    end
  end

  // Pin drivers: enable from direction, value from latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= '0;
    end else begin
      drive_q.oe <= dir_q & ~BPIO_IN_ONLY_MASK;
      drive_q.out <= data_q & dir_q & ~BPIO_IN_ONLY_MASK;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = drive_q.out;
  assign pin_oe = drive_q.oe;

  // Checks
  property p_dir_oe;
    @(posedge pclk) disable iff (!presetn)
      pin_oe == $past(dir_q & ~BPIO_IN_ONLY_MASK);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("oe not from dir");

  property p_reset_dir;
    @(posedge pclk) $rose(presetn) |-> dir_q == '0;
  endproperty
  a_reset_dir: assert property (p_reset_dir)
    else $error("dir not cleared");

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn)
      (dir_q & ~BPIO_DIR_MASK) == '0 && (pin_oe & ~BPIO_DIR_MASK) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimpl bit set");

  property p_in_only;
    @(posedge pclk) disable iff (!presetn) pin_oe[31] == 1'b0;
  endproperty
  a_in_only: assert property (p_in_only)
    else $error("input-only driven");

  property p_write_latch;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == BPIO_IDX_A_DATA && pstrb[0] |=>
        data_q[7:0] == $past(pwdata[7:0]);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("latch lost");

  property p_read_out;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok && idx == BPIO_IDX_C_DATA &&
      dir_q[23:16] == 8'hff |=> prdata[7:0] == $past(data_q[23:16]);
  endproperty
  a_read_out: assert property (p_read_out) else $error("latch not read");

  property p_read_in;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok && idx == BPIO_IDX_A_DATA &&
      dir_q[7:0] == 8'h00 |=> prdata[7:0] == $past(sync2_q[7:0]);
  endproperty
  a_read_in: assert property (p_read_in) else $error("pin not read");

  property p_dir_b;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == BPIO_IDX_B_DIR && pstrb[0] |=>
        dir_q[15:8] == ($past(pwdata[7:0]) & 8'he0);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("dir b wrong");

  property p_ready_one;
    @(posedge pclk) disable iff (!presetn) setup |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("bad ready");

  // Refused words answer at once with the error flag and zero data
  property p_err_answer;
    @(posedge pclk) disable iff (!presetn)
      setup && !addr_ok |=> pready && pslverr && prdata == '0;
  endproperty
  a_err_answer: assert property (p_err_answer)
    else $error("refused word answered wrongly");

  // Error flag never stands without ready
  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error flag outside ready");

  // Read data stands only in the answer cycle
  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn) !pready |-> prdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside ready");

  // A refused write leaves every direction bit alone
  property p_err_no_write;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !addr_ok |=> $stable(dir_q);
  endproperty
  a_err_no_write: assert property (p_err_no_write)
    else $error("refused write changed a direction");

  // Write with byte strobe off keeps the latch
  property p_strb_ignored;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == BPIO_IDX_A_DATA && !pstrb[0] |=>
        $stable(data_q[7:0]);
  endproperty
  a_strb_ignored: assert property (p_strb_ignored)
    else $error("strobe-off write changed latch");

  // First port direction reads back as stored
  property p_read_dir_a;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok && idx == BPIO_IDX_A_DIR |=>
        prdata[7:0] == $past(dir_q[7:0]);
  endproperty
  a_read_dir_a: assert property (p_read_dir_a)
    else $error("dir a read wrong");

  // Third port direction reads back as stored
  property p_read_dir_c;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok && idx == BPIO_IDX_C_DIR |=>
        prdata[7:0] == $past(dir_q[23:16]);
  endproperty
  a_read_dir_c: assert property (p_read_dir_c)
    else $error("dir c read wrong");

  // Input-only pin of the fourth port always reads the pin
  property p_read_d_in;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok && idx == BPIO_IDX_D_DATA |=>
        prdata[7] == $past(sync2_q[31]);
  endproperty
  a_read_d_in: assert property (p_read_d_in)
    else $error("input-only pin not read");

  // Second port low bits read zero in data and direction
  property p_b_low_zero;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && addr_ok &&
      (idx == BPIO_IDX_B_DATA || idx == BPIO_IDX_B_DIR) |=>
        prdata[4:0] == 5'h00;
  endproperty
  a_b_low_zero: assert property (p_b_low_zero)
    else $error("port b low bits not zero");

  // First port pins, when all eight are enabled, carry the latch
  property p_out_latch;
    @(posedge pclk) disable iff (!presetn)
      pin_oe[7:0] == 8'hff |-> pin_out[7:0] == $past(data_q[7:0]);
  endproperty
  a_out_latch: assert property (p_out_latch)
    else $error("pin not driven from latch");

  // First port direction takes the written byte
  property p_write_dir_a;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == BPIO_IDX_A_DIR && pstrb[0] |=>
        dir_q[7:0] == $past(pwdata[7:0]);
  endproperty
  a_write_dir_a: assert property (p_write_dir_a)
    else $error("dir a write lost");

  // Fourth port direction keeps only bit five
  property p_write_dir_d;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == BPIO_IDX_D_DIR && pstrb[0] |=>
        dir_q[31:24] == ($past(pwdata[7:0]) & 8'h20);
  endproperty
  a_write_dir_d: assert property (p_write_dir_d)
    else $error("dir d write wrong");

  c_write_dir: cover property (@(posedge pclk) wr_en && idx == BPIO_IDX_A_DIR);
  c_read_data: cover property (@(posedge pclk)
    setup && !pwrite && idx == BPIO_IDX_A_DATA);
  c_err: cover property (@(posedge pclk) pslverr);
  c_read_pin: cover property (@(posedge pclk)
    setup && !pwrite && idx == BPIO_IDX_A_DATA && dir_q[7:0] == 8'h00);
  c_strb_off: cover property (@(posedge pclk) wr_en && !pstrb[0]);
endmodule
`default_nettype wire

//--- testbench/bpio_pin_model.sv
// Board model: pins follow the port when driven
`timescale 1ns/10ps
`default_nettype none
module bpio_pin_model (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext,
  output logic [31:0] pin_in
);
  // Driven pins show the port, others the board
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

//--- testbench/bpio_ports_tb_top.sv
// Bench for the four-port I/O block
`timescale 1ns/10ps
`default_nettype none
module bpio_ports_tb_top;
  import bpio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, ext, rd;
  logic [7:0] lat [4];
  logic [7:0] dir [4];
  int fails, checked;
  bpio_ports i_bpio_ports (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  bpio_pin_model i_bpio_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext(ext), .pin_in(pin_in));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Expected read of one data port
  function automatic logic [31:0] exp_rd(int p);
    logic [7:0] d;
    d = dir[p] & BPIO_DIR_MASK[8*p+:8];
    return {24'h0, ((lat[p] & d) | (ext[8*p+:8] & ~d))
      & BPIO_DATA_MASK[8*p+:8]};
  endfunction
  // Expected output enables
  function automatic logic [31:0] exp_oe();
    logic [31:0] o;
    for (int p = 0; p < 4; p++) o[8*p+:8] = dir[p] & BPIO_DIR_MASK[8*p+:8];
    return o;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One APB transfer; waits on pready, then lets one edge pass
  task automatic apb(input logic w, input logic [3:0] i,
    input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h00, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    #50us;
    fails++;
    results();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pstrb = 4'hf;
    pwdata = 32'h0;
    ext = 32'h0;
    void'($urandom(22911));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 4'h8, 8'hff);
    chk({31'h0, e}, 32'h1);
    for (int i = 4; i < 8; i++) begin
      dir[i-4] = 8'h00;
      apb(1'b0, i[3:0], 8'h00);
      chk(rd, 32'h0);
    end
    apb(1'b0, 4'h8, 8'h00);
    chk({31'h0, e}, 32'h1);
    chk(rd, 32'h0);
    ext <= $urandom;
    repeat (4) @(posedge pclk);
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, p[3:0], 8'h00);
      chk(rd, exp_rd(p));
    end
    $display("reset and map test done");
    repeat (40) begin
      ext <= $urandom;
      for (int p = 0; p < 4; p++) begin
        lat[p] = 8'($urandom);
        apb(1'b1, p[3:0], lat[p]);
      end
      for (int p = 0; p < 4; p++) begin
        dir[p] = 8'($urandom);
        apb(1'b1, p[3:0] + 4'h4, dir[p]);
      end
      repeat (4) @(posedge pclk);
      chk(pin_oe, exp_oe());
      chk(pin_out, exp_oe() & {lat[3], lat[2], lat[1], lat[0]});
      for (int p = 0; p < 4; p++) begin
        apb(1'b0, p[3:0], 8'h00);
        chk(rd, exp_rd(p));
        apb(1'b0, p[3:0] + 4'h4, 8'h00);
        chk(rd, {24'h0, dir[p] & BPIO_DIR_MASK[8*p+:8]});
      end
    end
    $display("random port test done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pin_oe, 32'h0);
    for (int p = 0; p < 4; p++) begin
      dir[p] = 8'hff;
      apb(1'b1, p[3:0] + 4'h4, 8'hff);
    end
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, p[3:0], 8'h00);
      chk(rd, exp_rd(p));
    end
    pstrb <= 4'h0;
    apb(1'b1, 4'h0, ~lat[0]);
    pstrb <= 4'hf;
    apb(1'b0, 4'h0, 8'h00);
    chk(rd, exp_rd(0));
    $display("second reset test done");
    results();
  end
endmodule
`default_nettype wire
